// ---- hdl/tsf_table.sv ----
/*
  tsf_table: sixteen-entry signed table, written at the tail and read
  from either end; a two-entry skid buffer carries presented values.
  assumes coils come from logic on core_clk (no synchroniser needed)
  and that the consumer honours out_valid/out_ready.
*/
`timescale 1ns/1ps
`default_nettype none
module tsf_table #(
  parameter int DEPTH = tsf_pkg::TSF_DEPTH
) (
  input wire logic core_clk, // 250 MHz core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire tsf_pkg::tsf_coils_t coils, // enable, write, read, clear coils
  input wire tsf_pkg::tsf_word_t entry_input_value, // value captured on write
  output tsf_pkg::tsf_word_t entry_output_value, // presented value
  output logic out_valid, // presented value waiting in buffer
  input wire logic out_ready, // consumer takes presented value
  output logic in_ready, // buffer can take another value
  output tsf_pkg::tsf_status_t status // empty, full, count
);
  import tsf_pkg::*;

  // fill levels of the skid buffer; two words is all it holds
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam int N_COILS = $bits(tsf_coils_t);

  // table storage and its pointers
  tsf_word_t mem_q [DEPTH];
  tsf_word_t mem_d [DEPTH];
  logic [TSF_IDX_W-1:0] head_q;
  logic [TSF_IDX_W-1:0] head_d;
  logic [TSF_CNT_W-1:0] cnt_q;
  logic [TSF_CNT_W-1:0] cnt_d;

  // previous coil sample and the edges found against it
  tsf_coils_t prev_q;
  tsf_coils_t prev_d;
  logic [N_COILS-1:0] rise_v;
  tsf_coils_t rise;

  // operation chosen for this cycle
  logic do_wr;
  logic do_rf;
  logic do_rl;
  logic do_clr;
  logic push;
  logic pop;
  tsf_word_t push_val;
  logic [TSF_IDX_W-1:0] tail_idx;
  logic [TSF_IDX_W-1:0] last_idx;

  // skid buffer state
  tsf_word_t buf_q [2];
  tsf_word_t buf_d [2];
  logic rd_q;
  logic rd_d;
  logic wr_q;
  logic wr_d;
  logic [1:0] fill_q;
  logic [1:0] fill_d;

  // one rising-edge detector per coil; a coil held high gives one edge
  for (genvar gi = 0; gi < N_COILS; gi++) begin : g_rise
    assign rise_v[gi] = coils[gi] && !prev_q[gi];
  end
  assign rise = rise_v;

  // enable is a level, so an enable edge with a write edge in the
  // same cycle still writes; only one operation runs per cycle
  always_comb begin
    prev_d = coils;
    do_clr = coils.enable && rise.clear;
    do_wr = coils.enable && rise.write && !do_clr
      && (cnt_q != TSF_CNT_FULL) && in_ready;
    // oldest wins if both reads strike together; a read on empty is dropped
    do_rf = coils.enable && rise.read_oldest && !do_clr
      && !do_wr && (cnt_q != TSF_CNT_ZERO) && in_ready;
    do_rl = coils.enable && rise.read_newest && !do_clr
      && !do_wr && !do_rf && (cnt_q != TSF_CNT_ZERO) && in_ready;
  end

  // the previous sample updates every cycle, so a write or read edge met by a stalled buffer is lost
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  always_comb begin
    tail_idx = head_q + cnt_q[TSF_IDX_W-1:0];
    last_idx = tail_idx - TSF_IDX_ONE;
    mem_d = mem_q;
    head_d = head_q;
    cnt_d = cnt_q;
    push = 1'b0;
    push_val = entry_input_value;
    if (do_clr) begin
      head_d = '0;
      cnt_d = TSF_CNT_ZERO;
    end else if (do_wr) begin
      mem_d[tail_idx] = entry_input_value;
      cnt_d = cnt_q + TSF_CNT_ONE;
      push = 1'b1;
    end else if (do_rf) begin
      push_val = mem_q[head_q];
      head_d = head_q + TSF_IDX_ONE;
      cnt_d = cnt_q - TSF_CNT_ONE;
      push = 1'b1;
    end else if (do_rl) begin
      push_val = mem_q[last_idx];
      cnt_d = cnt_q - TSF_CNT_ONE;
      push = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      head_q <= '0;
      cnt_q <= TSF_CNT_ZERO;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= TSF_DATA_RST;
      end
    end else begin
      head_q <= head_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

  // two-entry buffer: a stalled consumer loses no presented word;
  // while it is full write and read edges are dropped; a clear edge still runs
  // limitation: the consumer must drain the buffer, or table ops stall
  assign in_ready = (fill_q != BUF_FULL);
  assign out_valid = (fill_q != BUF_EMPTY);
  assign entry_output_value = buf_q[rd_q];
  assign pop = out_valid && out_ready;

  // read and write slots toggle, so an empty buffer always has rd == wr
  always_comb begin
    buf_d = buf_q;
    rd_d = rd_q;
    wr_d = wr_q;
    fill_d = fill_q;
    if (push) begin
      buf_d[wr_q] = push_val;
      wr_d = !wr_q;
    end
    if (pop) begin
      rd_d = !rd_q;
    end
    fill_d = fill_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      buf_q[0] <= TSF_DATA_RST;
      buf_q[1] <= TSF_DATA_RST;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      fill_q <= BUF_EMPTY;
    end else begin
      buf_q <= buf_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      fill_q <= fill_d;
    end
  end

  assign status.empty = (cnt_q == TSF_CNT_ZERO);
  assign status.full = (cnt_q == TSF_CNT_FULL);
  assign status.count = cnt_q;
endmodule // tsf_table
`default_nettype wire

// ---- hdl/tsf_pkg.sv ----
/*
  tsf_pkg: constants and carrier types for the table stack block.
  assumes a single 250 MHz core clock; no bus, all controls are ports.
*/
`default_nettype none
package tsf_pkg;
  localparam int TSF_DATA_W = 32;
  localparam int TSF_DEPTH = 16;
  localparam int TSF_CNT_W = 5;
  localparam int TSF_IDX_W = 4;
  localparam logic [TSF_CNT_W-1:0] TSF_CNT_ZERO = 5'h00;
  localparam logic [TSF_CNT_W-1:0] TSF_CNT_ONE = 5'h01;
  localparam logic [TSF_CNT_W-1:0] TSF_CNT_FULL = 5'h10;
  localparam logic [TSF_IDX_W-1:0] TSF_IDX_ONE = 4'h1;
  localparam logic [TSF_DATA_W-1:0] TSF_DATA_RST = 32'h00000000;

  typedef logic signed [TSF_DATA_W-1:0] tsf_word_t;

  // coil group sampled each evaluation cycle
  typedef struct packed {
    logic enable;
    logic write;
    logic read_oldest;
    logic read_newest;
    logic clear;
  } tsf_coils_t;

  // status group presented to the circuit logic
  typedef struct packed {
    logic empty;
    logic full;
    logic [TSF_CNT_W-1:0] count;
  } tsf_status_t;
endpackage : tsf_pkg
`default_nettype wire

// ---- test/tsf_table_assertions.sv ----
/* port assertions for tsf_table.
   bound in the bench top; sees ports only. */
`timescale 1ns/1ps
`default_nettype none
module tsf_table_assertions #(parameter int DEPTH = 16) (
  input wire logic core_clk, // clk
  input wire logic rst_n, // rst
  input wire tsf_pkg::tsf_coils_t coils, // coils
  input wire tsf_pkg::tsf_word_t entry_input_value, // in
  input wire tsf_pkg::tsf_word_t entry_output_value, // out
  input wire logic out_valid, // ov
  input wire logic out_ready, // or
  input wire logic in_ready, // ir
  input wire tsf_pkg::tsf_status_t status // st
);
  import tsf_pkg::*;
  tsf_coils_t p_q;
  always_ff @(posedge core_clk) p_q <= rst_n ? coils : '0;
  // taken edges: bit 3 write, 2..1 reads, 0 clear
  wire logic [4:0] e = coils & ~p_q & {5{coils.enable && in_ready}};
  wire logic wr = e[3] && !e[0];
  wire logic rd = |e[2:1] && !e[3] && !e[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_empty_flag: assert property (status.empty == !status.count) else $error("empty");
  a_full_flag: assert property (status.full == (int'(status.count) == DEPTH))
    else $error("full");
  a_off_ignored: assert property (!coils.enable |=> $stable(status)) else $error("off");
  a_write_adds: assert property (wr && !status.full |=> status.count == $past(status.count) + 5'h01)
    else $error("write");
  a_read_drops: assert property (rd && !status.empty |=> status.count == $past(status.count) - 5'h01)
    else $error("read");
  a_clear_empties: assert property (e[0] |=> status.empty) else $error("clear");
  a_idle_read: assert property (rd && status.empty |=> status.empty) else $error("idle");
  a_full_holds: assert property (wr && status.full |=> status.full) else $error("hold");
  a_write_shows: assert property (wr && !status.full && !out_valid |=> out_valid &&
    entry_output_value == $past(entry_input_value)) else $error("shown");
  c_full: cover property (status.full);
  c_stall: cover property (!in_ready);
  c_newest: cover property (rd && e[1]);
endmodule // tsf_table_assertions
`default_nettype wire

// ---- test/tsf_partner.sv ----
/* consumer model: takes presented words, may stall.
   assumes the output handshake runs on core_clk. */
`timescale 1ns/1ps
`default_nettype none
module tsf_partner (
  input wire logic core_clk, // clk
  input wire logic slow, // ready one cycle in four
  input wire tsf_pkg::tsf_word_t entry_output_value, // word
  input wire logic out_valid, // word waiting
  output logic out_ready // take word
);
  import tsf_pkg::*;
  logic [1:0] ph_q = 2'h0;
  tsf_word_t seen[$];
  always_ff @(posedge core_clk) ph_q <= ph_q + 2'h1;
  assign out_ready = !slow || ph_q == 2'h3;
  always @(posedge core_clk) if (out_valid && out_ready) seen.push_back(entry_output_value);
endmodule // tsf_partner
`default_nettype wire

// ---- test/tsf_table_tb_top.sv ----
/* bench top: coil tasks, stalling consumer, status and word checks.
   assumes package, partner and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tsf_table_tb_top;
  import tsf_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, slow = 1'b1, out_valid, out_ready, in_ready;
  tsf_coils_t coils = '0;
  tsf_word_t entry_input_value = '0, entry_output_value;
  tsf_status_t status;
  int fail_count = 0, n_checks = 0;
  tsf_table u_tsf_table (.*);
  tsf_partner u_tsf_partner (.*);
  initial forever #2 core_clk = ~core_clk;
  task automatic wrap_up();
    $display("checks %0d fails %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic miss(string m);
    fail_count++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic cs(logic [4:0] n);
    n_checks++;
    if (status !== {n == 5'h00, n == 5'h10, n}) miss("status");
  endtask
  // drains the consumer first so the word is the last taken
  task automatic cw(tsf_word_t w);
    slow = 1'b0;
    repeat (6) @(negedge core_clk);
    n_checks++;
    if (u_tsf_partner.seen[$] !== w) miss("word");
  endtask
  // waits for buffer room: a write or read edge while it is full would be lost
  task automatic op(logic [4:0] m);
    while (!in_ready) @(negedge core_clk);
    coils = m;
    @(negedge core_clk);
    coils = m & 5'h10;
    repeat (2) @(negedge core_clk);
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    cs(5'h00);
    for (int k = 0; k < 16; k++) begin
      entry_input_value = 32'hFFFFFFF8 + k;
      op(5'h18);
    end
    cs(5'h10);
    op(5'h18);
    cs(5'h10);
    op(5'h14);
    cw(32'hFFFFFFF8);
    op(5'h12);
    cw(32'h00000007);
    cs(5'h0E);
    op(5'h01);
    cs(5'h0E);
    op(5'h11);
    op(5'h14);
    cs(5'h00);
    op(5'h00);
    entry_input_value = 32'h80000000;
    op(5'h18);
    cw(32'h80000000);
    cs(5'h01);
    wrap_up();
  end
  initial begin
    #20000;
    fail_count++;
    wrap_up();
  end
endmodule // tsf_table_tb_top
bind tsf_table tsf_table_assertions #(.DEPTH(DEPTH)) u_tsf_table_assertions (.*);
`default_nettype wire
